/* rtl/ccs_pkg.sv */
// constants and types shared by the core status and power control block
package ccs_pkg;

  // ----------------------------------------------------------------
  // register offsets on the special register port
  // ----------------------------------------------------------------
  localparam logic [7:0] SFR_PTR_LOW = 8'h82;
  localparam logic [7:0] SFR_PTR_HIGH = 8'h83;
  localparam logic [7:0] SFR_POWER_CTRL = 8'h87;
  localparam logic [7:0] SFR_STATUS_WORD = 8'hD0;
  localparam logic [7:0] SFR_MAIN_OPERAND = 8'hE0;
  localparam logic [7:0] SFR_SECOND_OPERAND = 8'hF0;

  // ----------------------------------------------------------------
  // reset values and fixed answers
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [15:0] RESTART_VECTOR = 16'h0000;

  // ----------------------------------------------------------------
  // status word field positions
  // ----------------------------------------------------------------
  localparam int PSW_CARRY = 7;
  localparam int PSW_HALF_CARRY = 6;
  localparam int PSW_USER_ZERO = 5;
  localparam int PSW_BANK_HIGH = 4;
  localparam int PSW_BANK_LOW = 3;
  localparam int PSW_SIGN_WRAP = 2;
  localparam int PSW_USER_ONE = 1;
  localparam int PSW_ODD = 0;

  // ----------------------------------------------------------------
  // power control field positions and bank layout
  // ----------------------------------------------------------------
  localparam int POWER_CONTROL_REG_IDLE = 0;
  localparam int POWER_CONTROL_REG_STOP = 1;
  localparam logic [2:0] BANK_OFFSET = 3'h0;

  // power management state
  typedef enum logic [2:0] {
    PWR_RUN,
    PWR_IDLE_ARM,
    PWR_IDLE,
    PWR_STOP_ARM,
    PWR_STOP
  } ccs_pwr_type;

endpackage : ccs_pkg

/* rtl/ccs_core_status.sv */
// core status registers, data pointer, operand registers and cpu power control
`timescale 1ns/1ps

module ccs_core_status
  import ccs_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // special register byte port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  // special register bit port
  input wire logic sfr_bit_wr,
  input wire logic [7:0] sfr_bit_addr,
  input wire logic sfr_bit_val,
  // arithmetic results from the execution unit
  input wire logic alu_cy_we,
  input wire logic alu_cy,
  input wire logic alu_ac,
  input wire logic alu_ov_we,
  input wire logic alu_ov,
  input wire logic alu_acc_we,
  input wire logic [7:0] alu_acc,
  input wire logic alu_b_we,
  input wire logic [7:0] alu_b,
  // instruction and interrupt status
  input wire logic instr_done,
  input wire logic irq_pending_en,
  // reset sources
  input wire logic wdt_enabled,
  input wire logic wdt_expire,
  input wire logic lcd_enabled,
  input wire logic lcd_expire,
  input wire logic ext_reset_pin,
  // register contents toward the core
  output logic [15:0] data_pointer_pair,
  output logic [7:0] main_operand,
  output logic [7:0] second_operand,
  output logic [7:0] status_word,
  output logic [1:0] bank_select,
  output logic [7:0] bank_base,
  // power control outputs
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic int_osc_en,
  output logic lcd_active,
  output logic idle_wake,
  output logic reset_request,
  output logic restart_req,
  output logic [15:0] restart_addr
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] ptr_low_reg;
  logic [7:0] ptr_high_reg;
  logic [7:0] acc_reg;
  logic [7:0] acc_next;
  logic [7:0] b_reg;
  logic [7:0] b_next;
  logic [7:0] psw_reg;
  logic [7:0] psw_next;
  logic [7:0] rdata_reg;
  ccs_pwr_type pwr_reg;
  ccs_pwr_type pwr_next;
  logic wake_reg;
  logic rst_req_reg;
  logic restart_reg;
  logic ext_meta_reg;
  logic ext_sync_reg;
  logic odd_flag;
  logic [7:0] bit_byte;
  logic power_control_reg_wr;

  // sets one bit of a byte when the bit port targets that byte
  function automatic logic [7:0] ccs_bit_merge(input logic [7:0] cur, input logic [7:0] base);
    logic [7:0] res;
    res = cur;
    if (sfr_bit_wr && bit_byte == base) begin
      res[sfr_bit_addr[2:0]] = sfr_bit_val;
    end
    return res;
  endfunction : ccs_bit_merge

  assign bit_byte = {sfr_bit_addr[7:3], 3'h0};
  assign power_control_reg_wr = sfr_wr && sfr_addr == SFR_POWER_CTRL;
  assign odd_flag = ^acc_reg;

  // ----------------------------------------------------------------
  // data pointer pair
  // ----------------------------------------------------------------
  // byte registers only; the pair is just the concatenation
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ptr_high_reg <= RESET_BYTE;
      ptr_low_reg <= RESET_BYTE;
    end else begin
      if (sfr_wr && sfr_addr == SFR_PTR_HIGH) begin
        ptr_high_reg <= sfr_wdata;
      end
      if (sfr_wr && sfr_addr == SFR_PTR_LOW) begin
        ptr_low_reg <= sfr_wdata;
      end
    end
  end

  assign data_pointer_pair = {ptr_high_reg, ptr_low_reg};

  // ----------------------------------------------------------------
  // operand registers and status word next values
  // ----------------------------------------------------------------
  // execution results are applied last so a hardware update beats a
  // software write in the same cycle
  always_comb begin
    acc_next = acc_reg;
    if (sfr_wr && sfr_addr == SFR_MAIN_OPERAND) begin
      acc_next = sfr_wdata;
    end
    acc_next = ccs_bit_merge(acc_next, SFR_MAIN_OPERAND);
    if (alu_acc_we) begin
      acc_next = alu_acc;
    end
    b_next = b_reg;
    if (sfr_wr && sfr_addr == SFR_SECOND_OPERAND) begin
      b_next = sfr_wdata;
    end
    b_next = ccs_bit_merge(b_next, SFR_SECOND_OPERAND);
    if (alu_b_we) begin
      b_next = alu_b;
    end
    psw_next = psw_reg;
    if (sfr_wr && sfr_addr == SFR_STATUS_WORD) begin
      psw_next = sfr_wdata;
    end
    psw_next = ccs_bit_merge(psw_next, SFR_STATUS_WORD);
    if (alu_cy_we) begin
      psw_next[PSW_CARRY] = alu_cy;
      psw_next[PSW_HALF_CARRY] = alu_ac;
    end
    if (alu_ov_we) begin
      psw_next[PSW_SIGN_WRAP] = alu_ov;
    end
    // odd flag is derived, so the stored bit is never kept
    psw_next[PSW_ODD] = 1'b0;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      acc_reg <= RESET_BYTE;
      b_reg <= RESET_BYTE;
      psw_reg <= RESET_BYTE;
    end else begin
      acc_reg <= acc_next;
      b_reg <= b_next;
      psw_reg <= psw_next;
    end
  end

  assign main_operand = acc_reg;
  assign second_operand = b_reg;
  assign status_word = {psw_reg[7:1], odd_flag};
  assign bank_select = {psw_reg[PSW_BANK_HIGH], psw_reg[PSW_BANK_LOW]};
  assign bank_base = {3'h0, bank_select, BANK_OFFSET};

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // registered answer one cycle after the read; unmapped reads return zero
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata_reg <= READ_ZERO;
    end else if (sfr_rd) begin
      case (sfr_addr)
        SFR_PTR_LOW: rdata_reg <= ptr_low_reg;
        SFR_PTR_HIGH: rdata_reg <= ptr_high_reg;
        SFR_POWER_CTRL: rdata_reg <= READ_ZERO;
        SFR_STATUS_WORD: rdata_reg <= status_word;
        SFR_MAIN_OPERAND: rdata_reg <= acc_reg;
        SFR_SECOND_OPERAND: rdata_reg <= b_reg;
        default: rdata_reg <= READ_ZERO;
      endcase
    end
  end

  assign sfr_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------
  // a select write arms the mode; the mode starts when the writing
  // instruction reports completion, which may be the same cycle
  always_comb begin
    pwr_next = pwr_reg;
    case (pwr_reg)
      PWR_RUN: begin
        if (power_control_reg_wr && sfr_wdata[POWER_CONTROL_REG_STOP]) begin
          pwr_next = instr_done ? PWR_STOP : PWR_STOP_ARM;
        end else if (power_control_reg_wr && sfr_wdata[POWER_CONTROL_REG_IDLE]) begin
          pwr_next = instr_done ? PWR_IDLE : PWR_IDLE_ARM;
        end
      end
      PWR_IDLE_ARM: begin
        if (instr_done) begin
          pwr_next = PWR_IDLE;
        end
      end
      PWR_IDLE: begin
        if (irq_pending_en) begin
          pwr_next = PWR_RUN;
        end
      end
      PWR_STOP_ARM: begin
        if (instr_done) begin
          pwr_next = PWR_STOP;
        end
      end
      PWR_STOP: pwr_next = PWR_STOP;
      default: pwr_next = PWR_RUN;
    endcase
  end

  // reset alone returns the machine from stop to run; an enabled interrupt also ends idle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pwr_reg <= PWR_RUN;
      wake_reg <= 1'b0;
    end else begin
      pwr_reg <= pwr_next;
      wake_reg <= pwr_reg == PWR_IDLE && irq_pending_en;
    end
  end

  // clocks stay on while only armed, so the instruction can finish
  assign cpu_clk_en = pwr_reg != PWR_IDLE && pwr_reg != PWR_STOP;
  assign periph_clk_en = pwr_reg != PWR_STOP;
  assign int_osc_en = pwr_reg != PWR_STOP;
  assign lcd_active = lcd_enabled;
  assign idle_wake = wake_reg;

  // ----------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------
  // the pin is asynchronous; only the second stage is looked at
  always_ff @(posedge clk_sys) begin
    ext_meta_reg <= ext_reset_pin;
    ext_sync_reg <= ext_meta_reg;
  end

  // watchdog is a timer and is frozen in stop; the detector is not
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rst_req_reg <= 1'b0;
    end else begin
      rst_req_reg <= ext_sync_reg
        || (wdt_enabled && wdt_expire && pwr_reg != PWR_STOP)
        || (lcd_enabled && lcd_expire);
    end
  end

  assign reset_request = rst_req_reg;

  // restart request high through reset, drops at the first edge after
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      restart_reg <= 1'b1;
    end else begin
      restart_reg <= 1'b0;
    end
  end

  assign restart_req = restart_reg;
  assign restart_addr = RESTART_VECTOR;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_PTR_HIGH: assert property (@(posedge clk_sys) disable iff (reset)
    sfr_wr && sfr_addr == SFR_PTR_HIGH |=> data_pointer_pair[15:8] == $past(sfr_wdata))
    else $error("pointer high byte not loaded");
  AST_PTR_LOW: assert property (@(posedge clk_sys) disable iff (reset)
    sfr_wr && sfr_addr == SFR_PTR_LOW |=> data_pointer_pair[7:0] == $past(sfr_wdata))
    else $error("pointer low byte not loaded");
  AST_CARRY: assert property (@(posedge clk_sys) disable iff (reset)
    alu_cy_we |=> status_word[PSW_CARRY] == $past(alu_cy))
    else $error("carry flag does not follow arithmetic");
  AST_HALF_CARRY: assert property (@(posedge clk_sys) disable iff (reset)
    alu_cy_we |=> status_word[PSW_HALF_CARRY] == $past(alu_ac))
    else $error("half carry flag does not follow arithmetic");
  AST_USER_FLAGS: assert property (@(posedge clk_sys) disable iff (reset)
    !(sfr_wr && sfr_addr == SFR_STATUS_WORD) && !sfr_bit_wr
    |=> $stable({status_word[PSW_USER_ZERO], status_word[PSW_USER_ONE]}))
    else $error("user flag changed without software");
  AST_BANK_BASE: assert property (@(posedge clk_sys) disable iff (reset)
    bank_base == {3'h0, status_word[PSW_BANK_HIGH], status_word[PSW_BANK_LOW], 3'h0})
    else $error("bank base disagrees with bank select");
  AST_SIGN_WRAP: assert property (@(posedge clk_sys) disable iff (reset)
    alu_ov_we |=> status_word[PSW_SIGN_WRAP] == $past(alu_ov))
    else $error("sign wrap flag wrong after arithmetic");
  AST_ODD: assert property (@(posedge clk_sys) disable iff (reset)
    status_word[PSW_ODD] == ^main_operand)
    else $error("odd flag disagrees with accumulator");
  AST_POWER_CONTROL_REG_READ: assert property (@(posedge clk_sys) disable iff (reset)
    sfr_rd && sfr_addr == SFR_POWER_CTRL |=> sfr_rdata == READ_ZERO)
    else $error("power control read not zero");
  AST_IDLE_ENTER: assert property (@(posedge clk_sys) disable iff (reset)
    pwr_reg == PWR_IDLE_ARM && instr_done |=> !cpu_clk_en && periph_clk_en)
    else $error("idle not entered after instruction");
  AST_IDLE_WAKE: assert property (@(posedge clk_sys) disable iff (reset)
    pwr_reg == PWR_IDLE && irq_pending_en |=> cpu_clk_en && idle_wake)
    else $error("enabled interrupt did not end idle");
  AST_STOP_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
    pwr_reg == PWR_STOP |=> pwr_reg == PWR_STOP && !int_osc_en && !periph_clk_en)
    else $error("stop left without reset");
  AST_STOP_WINS: assert property (@(posedge clk_sys) disable iff (reset)
    pwr_reg == PWR_RUN && power_control_reg_wr && sfr_wdata[POWER_CONTROL_REG_STOP] && instr_done |=> pwr_reg == PWR_STOP)
    else $error("stop did not win over idle");
  AST_LCD_RESET: assert property (@(posedge clk_sys) disable iff (reset)
    lcd_enabled && lcd_expire |=> reset_request)
    else $error("detector expiry raised no reset");
  AST_WDT_RESET: assert property (@(posedge clk_sys) disable iff (reset)
    wdt_enabled && wdt_expire && pwr_reg != PWR_STOP |=> reset_request)
    else $error("watchdog expiry raised no reset");
  AST_STOP_QUIET: assert property (@(posedge clk_sys) disable iff (reset)
    pwr_reg == PWR_STOP && !ext_sync_reg && !(lcd_enabled && lcd_expire) |=> !reset_request)
    else $error("frozen source raised a reset in stop");

endmodule : ccs_core_status

/* verif/ccs_cpu_model.sv */
// execution unit and interrupt side model feeding the status block
`timescale 1ns/1ps
module ccs_cpu_model (
  // clock
  input wire logic clk_sys,
  // arithmetic results
  output logic alu_cy_we,
  output logic alu_cy,
  output logic alu_ac,
  output logic alu_ov_we,
  output logic alu_ov,
  output logic alu_acc_we,
  output logic [7:0] alu_acc,
  output logic alu_b_we,
  output logic [7:0] alu_b,
  // instruction and interrupt status
  output logic instr_done,
  output logic irq_pending_en,
  // reset sources
  output logic wdt_enabled,
  output logic wdt_expire,
  output logic lcd_enabled,
  output logic lcd_expire
);
  // both reset sources start enabled so an expiry counts until enables turns them off
  initial begin
    {alu_cy_we, alu_cy, alu_ac, alu_ov_we, alu_ov, alu_acc_we, alu_b_we} = 7'h00;
    {instr_done, irq_pending_en, wdt_expire, lcd_expire} = 4'h0;
    {wdt_enabled, lcd_enabled, alu_acc, alu_b} = {2'b11, 16'hA55A};
  end
  // flag update; data flips afterwards so stale values never pass as valid
  task flags(input logic cy, input logic ac, input logic ov);
    @(negedge clk_sys);
    {alu_cy_we, alu_ov_we, alu_cy, alu_ac, alu_ov} = {2'b11, cy, ac, ov};
    @(negedge clk_sys);
    {alu_cy_we, alu_ov_we, alu_cy, alu_ac, alu_ov} = {2'b00, ~cy, ~ac, ~ov};
  endtask : flags
  // operand loads
  task load(input logic [7:0] acc, input logic [7:0] bv);
    @(negedge clk_sys);
    {alu_acc_we, alu_b_we, alu_acc, alu_b} = {2'b11, acc, bv};
    @(negedge clk_sys);
    {alu_acc_we, alu_b_we, alu_acc, alu_b} = {2'b00, ~acc, ~bv};
  endtask : load
  // end of current instruction
  task done();
    @(negedge clk_sys);
    instr_done = 1'b1;
    @(negedge clk_sys);
    instr_done = 1'b0;
  endtask : done
  // enabled interrupt level
  task irq(input logic v);
    @(negedge clk_sys);
    irq_pending_en = v;
  endtask : irq
  // enable levels of the two reset sources
  task enables(input logic w, input logic l);
    @(negedge clk_sys);
    {wdt_enabled, lcd_enabled} = {w, l};
  endtask : enables
  // one expiry pulse, detector when lcd is high, else watchdog
  task expire(input logic lcd);
    @(negedge clk_sys);
    {lcd_expire, wdt_expire} = {lcd, ~lcd};
    @(negedge clk_sys);
    {lcd_expire, wdt_expire} = 2'b00;
  endtask : expire
endmodule : ccs_cpu_model

/* verif/ccs_core_status_test.sv */
// self-checking bench for the core status and power control block
`timescale 1ns/1ps
module ccs_core_status_test;
  import ccs_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_bit_addr = 8'h00;
  logic sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_bit_wr = 1'b0, sfr_bit_val = 1'b0, ext_reset_pin = 1'b0;
  logic alu_cy_we, alu_cy, alu_ac, alu_ov_we, alu_ov, alu_acc_we, alu_b_we, instr_done, irq_pending_en;
  logic wdt_enabled, wdt_expire, lcd_enabled, lcd_expire, rd_d = 1'b0;
  logic [7:0] alu_acc, alu_b, sfr_rdata, main_operand, second_operand, status_word, bank_base, a, b;
  logic [15:0] data_pointer_pair, restart_addr;
  logic [1:0] bank_select;
  logic cpu_clk_en, periph_clk_en, int_osc_en, lcd_active, idle_wake, reset_request, restart_req;
  logic [7:0] regs [7] = '{SFR_PTR_LOW, SFR_PTR_HIGH, SFR_POWER_CTRL, SFR_STATUS_WORD,
    SFR_MAIN_OPERAND, SFR_SECOND_OPERAND, 8'h81};
  int err_total = 0, comparisons = 0, cycles = 0, n;
  string nq[$];
  logic [7:0] eq[$];

  ccs_core_status dut (.clk_sys(clk_sys), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_bit_wr(sfr_bit_wr),
    .sfr_bit_addr(sfr_bit_addr), .sfr_bit_val(sfr_bit_val), .alu_cy_we(alu_cy_we), .alu_cy(alu_cy),
    .alu_ac(alu_ac), .alu_ov_we(alu_ov_we), .alu_ov(alu_ov), .alu_acc_we(alu_acc_we), .alu_acc(alu_acc),
    .alu_b_we(alu_b_we), .alu_b(alu_b), .instr_done(instr_done), .irq_pending_en(irq_pending_en),
    .wdt_enabled(wdt_enabled), .wdt_expire(wdt_expire), .lcd_enabled(lcd_enabled),
    .lcd_expire(lcd_expire), .ext_reset_pin(ext_reset_pin), .data_pointer_pair(data_pointer_pair),
    .main_operand(main_operand), .second_operand(second_operand), .status_word(status_word),
    .bank_select(bank_select), .bank_base(bank_base), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .int_osc_en(int_osc_en), .lcd_active(lcd_active),
    .idle_wake(idle_wake), .reset_request(reset_request), .restart_req(restart_req),
    .restart_addr(restart_addr));
  ccs_cpu_model cpu (.clk_sys(clk_sys), .alu_cy_we(alu_cy_we), .alu_cy(alu_cy), .alu_ac(alu_ac),
    .alu_ov_we(alu_ov_we), .alu_ov(alu_ov), .alu_acc_we(alu_acc_we), .alu_acc(alu_acc),
    .alu_b_we(alu_b_we), .alu_b(alu_b), .instr_done(instr_done), .irq_pending_en(irq_pending_en),
    .wdt_enabled(wdt_enabled), .wdt_expire(wdt_expire), .lcd_enabled(lcd_enabled),
    .lcd_expire(lcd_expire));

  // 40 MHz clock and a hang limit far above the real run length
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    rd_d <= sfr_rd;
    if (cycles == 3000) begin
      err_total++;
      results();
    end
  end
  // read answers are settled by the falling edge after the taking edge
  always @(negedge clk_sys) begin
    if (rd_d && nq.size() > 0) chk(nq.pop_front(), 16'(sfr_rdata), 16'(eq.pop_front()));
  end

  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // byte write; data flips after release so nothing leans on it
  task wr(input logic [7:0] ad, input logic [7:0] d);
    @(negedge clk_sys);
    {sfr_addr, sfr_wdata, sfr_wr} = {ad, d, 1'b1};
    @(negedge clk_sys);
    {sfr_wdata, sfr_wr} = {~d, 1'b0};
  endtask : wr
  task bw(input logic [7:0] ad, input logic v);
    @(negedge clk_sys);
    {sfr_bit_addr, sfr_bit_val, sfr_bit_wr} = {ad, v, 1'b1};
    @(negedge clk_sys);
    {sfr_bit_val, sfr_bit_wr} = {~v, 1'b0};
  endtask : bw
  task rd(input logic [7:0] ad, input logic [7:0] e, input string nm);
    nq.push_back(nm);
    eq.push_back(e);
    @(negedge clk_sys);
    {sfr_addr, sfr_rd} = {ad, 1'b1};
    @(negedge clk_sys);
    sfr_rd = 1'b0;
  endtask : rd
  // reset as the system would on reset_request
  task hard_reset();
    @(negedge clk_sys);
    reset = 1'b1;
    @(negedge clk_sys);
    chk("restart", restart_req, 1'b1);
    chk("restart address", restart_addr, RESTART_VECTOR);
    reset = 1'b0;
    @(negedge clk_sys);
    chk("run again", {restart_req, cpu_clk_en, periph_clk_en}, 3'b011);
  endtask : hard_reset
  task results();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  initial begin
    void'($urandom(32'hE29C));
    repeat (10) @(negedge clk_sys);
    reset = 1'b0;
    foreach (regs[i]) rd(regs[i], 8'h00, "reset value");
    a = 8'($urandom);
    b = 8'($urandom);
    wr(SFR_PTR_HIGH, a);
    wr(SFR_PTR_LOW, b);
    chk("pointer", data_pointer_pair, {a, b});
    rd(SFR_PTR_HIGH, a, "pointer high");
    wr(8'h81, a);
    rd(8'h81, 8'h00, "unmapped");
    wr(SFR_MAIN_OPERAND, a);
    wr(SFR_SECOND_OPERAND, b);
    rd(SFR_MAIN_OPERAND, a, "main operand");
    rd(SFR_SECOND_OPERAND, b, "second operand");
    wr(SFR_STATUS_WORD, 8'hFF);
    rd(SFR_STATUS_WORD, {7'h7F, ^a}, "status");
    cpu.load(b, a);
    chk("loads", {main_operand, second_operand}, {b, a});
    bw(8'hD0, ~^b);
    chk("odd flag", status_word[0], ^b);
    bw(8'hE7, ~b[7]);
    chk("bit write", main_operand, {~b[7], b[6:0]});
    for (int i = 0; i < 4; i++) begin
      wr(SFR_STATUS_WORD, 8'(i * 8));
      chk("bank", {bank_select, bank_base}, {2'(i), 8'(i * 8)});
    end
    bw(8'hD5, 1'b1);
    bw(8'hD1, 1'b1);
    cpu.flags(1'b1, 1'b0, 1'b1);
    chk("flags a", status_word[7:1], 7'b1011111);
    cpu.flags(1'b0, 1'b1, 1'b0);
    chk("flags b", status_word[7:1], 7'b0111101);
    // idle: armed until the instruction ends, then woken by an interrupt
    wr(SFR_POWER_CTRL, 8'h01);
    rd(SFR_POWER_CTRL, 8'h00, "power readback");
    chk("armed", cpu_clk_en, 1'b1);
    cpu.done();
    chk("idle", {cpu_clk_en, periph_clk_en, int_osc_en}, 3'b011);
    cpu.irq(1'b1);
    for (n = 0; n < 4 && idle_wake !== 1'b1; n++) @(negedge clk_sys);
    chk("wake", {idle_wake, cpu_clk_en}, 2'b11);
    chk("kept", main_operand, {~b[7], b[6:0]});
    cpu.irq(1'b0);
    wr(SFR_POWER_CTRL, 8'h01);
    cpu.done();
    cpu.expire(1'b0);
    chk("watchdog", reset_request, 1'b1);
    hard_reset();
    // disabled sources must not reset; the pin resets through its synchroniser
    cpu.enables(1'b0, 1'b0);
    cpu.expire(1'b0);
    cpu.expire(1'b1);
    chk("disabled", {reset_request, lcd_active}, 2'b00);
    cpu.enables(1'b1, 1'b1);
    @(negedge clk_sys);
    ext_reset_pin = 1'b1;
    @(negedge clk_sys);
    ext_reset_pin = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("pin reset", reset_request, 1'b1);
    hard_reset();
    // stop wins over idle and ignores interrupts and the watchdog
    wr(SFR_POWER_CTRL, 8'h03);
    cpu.done();
    chk("stop", {cpu_clk_en, periph_clk_en, int_osc_en}, 3'b000);
    cpu.irq(1'b1);
    cpu.expire(1'b0);
    chk("stop holds", {cpu_clk_en, idle_wake, reset_request}, 3'b000);
    cpu.irq(1'b0);
    cpu.expire(1'b1);
    chk("detector", {reset_request, lcd_active}, 2'b11);
    hard_reset();
    repeat (3) @(negedge clk_sys);
    results();
  end
endmodule : ccs_core_status_test
